// ===== core/ats_consts.svh
// Register offsets, field positions and reset values of the conversion sequencer
`ifndef ATS_CONSTS_SVH
`define ATS_CONSTS_SVH
`define ATS_OFS_CTRL     8'h00
`define ATS_OFS_CLK      8'h04
`define ATS_OFS_MODE3    8'h08
`define ATS_OFS_MONA     8'h0C
`define ATS_OFS_MONB     8'h10
`define ATS_OFS_CMPA     8'h14
`define ATS_OFS_CMPB     8'h18
`define ATS_OFS_STATUS   8'h1C
`define ATS_OFS_PSEL     8'h20
`define ATS_OFS_PINTS    8'h24
`define ATS_OFS_PSET0    8'h40
`define ATS_OFS_TSET0    8'h60
`define ATS_OFS_SSET0    8'h70
`define ATS_OFS_ASET0    8'h80
`define ATS_OFS_RES0     8'hC0
`define ATS_CTRL_EN      0
`define ATS_CTRL_SOFT    1
`define ATS_CTRL_CONST   2
`define ATS_SLOT_EN      7
`define ATS_MON_EN       5
`define ATS_MON_BIG      4
`define ATS_RES_OVR      30
`define ATS_RES_RF       31
`define ATS_PINTS_EN     1
`define ATS_MODE3_RST    8'h04
`define ATS_CLK_RST      4'h0
`define ATS_NUM_INPUTS   5'h05
`define ATS_SLOTS        12
`define ATS_MSLOTS       4
`endif

// ===== core/ats_pkg.sv
// Types of the conversion sequencer
package ats_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } ats_state_e;
  typedef enum logic [4:0] {
    K_NONE  = 5'b00001,
    K_CONST = 5'b00010,
    K_SOFT  = 5'b00100,
    K_TIMER = 5'b01000,
    K_MOTOR = 5'b10000
  } ats_kind_e;
  typedef struct packed {
    ats_state_e         st;
    ats_kind_e          kind;
    logic [2:0]         prog;
    logic [3:0]         slot;
    logic [5:0]         mpend;
    logic               tpend;
    logic               spend;
    logic               en;
    logic               cen;
    logic [3:0]         clk;
    logic [7:0]         mode3;
    logic [5:0]         mona;
    logic [5:0]         monb;
    logic [11:0]        cmpa;
    logic [11:0]        cmpb;
    logic [17:0]        psel;
    logic [11:0]        pints;
    logic [5:0][31:0]   pset;
    logic [2:0][31:0]   tset;
    logic [2:0][31:0]   sset;
    logic [2:0][31:0]   aset;
    logic [11:0][11:0]  res;
    logic [11:0]        rf;
    logic [11:0]        ovr;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
    logic               cstart;
    logic               cabort;
    logic [2:0]         cin;
    logic [1:0]         cph;
    logic [1:0]         mdone;
    logic               tdone;
    logic               sdone;
    logic               adone;
    logic [1:0]         mon;
  } ats_state_s;
endpackage

// ===== core/ats_top.sv
// Trigger sequencer for a 12-bit successive-approximation converter
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ats_consts.svh"
module ats_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [5:0]  motor_trigger_in,
  input  wire logic        timer_start_pulse,
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_data,
  output logic             conv_start,
  output logic             conv_abort,
  output logic [2:0]       conv_input,
  output logic [1:0]       conv_phase,
  output logic [3:0]       conv_clock_select_reg,
  output logic [2:0]       operating_mode_field,
  output logic             converter_enable,
  output logic [1:0]       motor_prog_done_irq,
  output logic             timer_prog_done_irq,
  output logic             soft_prog_done_irq,
  output logic             const_prog_done_irq,
  output logic [1:0]       monitor_match_irq
);
  ats_pkg::ats_state_s s;       // All state
  ats_pkg::ats_state_s next_s;  // Its next value

  // Priority rank, constant lowest
  function automatic logic [2:0] rank(input ats_pkg::ats_kind_e k);
    case (k)
      ats_pkg::K_MOTOR: rank = 3'h4;
      ats_pkg::K_TIMER: rank = 3'h3;
      ats_pkg::K_SOFT:  rank = 3'h2;
      ats_pkg::K_CONST: rank = 3'h1;
      default:          rank = 3'h0;
    endcase
  endfunction

  // Slot byte of a program: input [4:0], phase [6:5], enable [7]
  function automatic logic [7:0] slot_byte(input ats_pkg::ats_state_s x,
                                           input logic [3:0] i);
    case (x.kind)
      ats_pkg::K_MOTOR: slot_byte = x.pset[x.prog][i[1:0]*8 +: 8];
      ats_pkg::K_TIMER: slot_byte = x.tset[i[3:2]][i[1:0]*8 +: 8];
      ats_pkg::K_SOFT:  slot_byte = x.sset[i[3:2]][i[1:0]*8 +: 8];
      ats_pkg::K_CONST: slot_byte = x.aset[i[3:2]][i[1:0]*8 +: 8];
      default:          slot_byte = 8'h00;
    endcase
  endfunction

  // Input code to converter input; codes past the last input fall to 0
  function automatic logic [2:0] map_input(input logic [4:0] c);
    map_input = (c < `ATS_NUM_INPUTS) ? c[2:0] : 3'h0;
  endfunction

  // First enabled slot at or after from; {found, index}
  function automatic logic [4:0] next_slot(input ats_pkg::ats_state_s x,
                                           input logic [3:0] from);
    logic [4:0] r;
    logic [3:0] n;
    logic [7:0] b; // Slot byte under test
    r = 5'h00;
    b = 8'h00;
    n = (x.kind == ats_pkg::K_MOTOR) ? 4'(`ATS_MSLOTS) : 4'(`ATS_SLOTS);
    for (int i = `ATS_SLOTS - 1; i >= 0; i--) begin
      b = slot_byte(x, 4'(i));
      if (4'(i) >= from && 4'(i) < n && b[`ATS_SLOT_EN]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // Program end: completion pulse (motor only if its pints enable bit is set), then idle
  function automatic ats_pkg::ats_state_s finish(input ats_pkg::ats_state_s x);
    ats_pkg::ats_state_s y;
    logic [1:0]          sel;
    y = x;
    sel = x.pints[x.prog*2 +: 2];
    case (x.kind)
      ats_pkg::K_MOTOR: begin
        if (sel[`ATS_PINTS_EN]) begin
          y.mdone[sel[0]] = 1'b1;
        end
      end
      ats_pkg::K_TIMER: begin
        y.tdone = 1'b1;
        y.tpend = 1'b0;
      end
      ats_pkg::K_SOFT: begin
        y.sdone = 1'b1;
        y.spend = 1'b0;
      end
      ats_pkg::K_CONST: y.adone = 1'b1;
      default: ;
    endcase
    y.st = ats_pkg::ST_IDLE;
    y.kind = ats_pkg::K_NONE;
    return y;
  endfunction

  // Issue the next enabled slot, or finish the program
  function automatic ats_pkg::ats_state_s issue(input ats_pkg::ats_state_s x,
                                                input logic [3:0] from);
    ats_pkg::ats_state_s y;
    logic [4:0]          f;
    logic [7:0]          b;
    y = x;
    f = (from < 4'(`ATS_SLOTS)) ? next_slot(x, from) : 5'h00;
    b = slot_byte(x, f[3:0]);
    if (f[4]) begin
      y.st = ats_pkg::ST_BUSY;
      y.slot = f[3:0];
      y.cstart = 1'b1;
      y.cin = map_input(b[4:0]);
      y.cph = (x.kind == ats_pkg::K_MOTOR) ? b[6:5] : 2'h0;
    end else begin
      y = finish(x);
    end
    return y;
  endfunction

  // Whole next-state logic
  always_comb begin
    ats_pkg::ats_kind_e want;
    logic [2:0]         j;
    logic [7:0]         a;
    logic [3:0]         r;
    next_s = s;
    want = ats_pkg::K_NONE;
    j = 3'h0;
    a = paddr;
    r = 4'h0;
    // Pulses last one cycle
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.cstart = 1'b0;
    next_s.cabort = 1'b0;
    next_s.mdone = 2'h0;
    next_s.tdone = 1'b0;
    next_s.sdone = 1'b0;
    next_s.adone = 1'b0;
    next_s.mon = 2'h0;
    // Trigger capture; motor triggers queue while a motor program runs
    next_s.mpend = s.mpend | motor_trigger_in;
    next_s.tpend = s.tpend | timer_start_pulse;
    // APB access phase, answered one cycle after it opens
    if (psel && penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      if (a >= `ATS_OFS_RES0 && a < `ATS_OFS_RES0 + 8'h30) begin
        r = 4'((a - `ATS_OFS_RES0) >> 2);
        next_s.prdata = {s.rf[r], s.ovr[r], 18'h0, s.res[r]};
        if (!pwrite) begin
          next_s.rf[r] = 1'b0;
          next_s.ovr[r] = 1'b0;
        end
      end else if (a >= `ATS_OFS_PSET0 && a < `ATS_OFS_PSET0 + 8'h18) begin
        r = 4'((a - `ATS_OFS_PSET0) >> 2);
        next_s.prdata = s.pset[r];
        if (pwrite) next_s.pset[r] = pwdata;
      end else if (a >= `ATS_OFS_TSET0 && a < `ATS_OFS_TSET0 + 8'h0C) begin
        r = 4'((a - `ATS_OFS_TSET0) >> 2);
        next_s.prdata = s.tset[r];
        if (pwrite) next_s.tset[r] = pwdata;
      end else if (a >= `ATS_OFS_SSET0 && a < `ATS_OFS_SSET0 + 8'h0C) begin
        r = 4'((a - `ATS_OFS_SSET0) >> 2);
        next_s.prdata = s.sset[r];
        if (pwrite) next_s.sset[r] = pwdata;
      end else if (a >= `ATS_OFS_ASET0 && a < `ATS_OFS_ASET0 + 8'h0C) begin
        r = 4'((a - `ATS_OFS_ASET0) >> 2);
        next_s.prdata = s.aset[r];
        if (pwrite) next_s.aset[r] = pwdata;
      end else begin
        case (a)
          `ATS_OFS_CTRL: begin
            next_s.prdata = {29'h0, s.cen, s.spend, s.en};
            if (pwrite) begin
              next_s.en = pwdata[`ATS_CTRL_EN];
              next_s.cen = pwdata[`ATS_CTRL_CONST];
              next_s.spend = s.spend | pwdata[`ATS_CTRL_SOFT];
            end
          end
          `ATS_OFS_CLK: begin
            next_s.prdata = {28'h0, s.clk};
            if (pwrite) next_s.clk = pwdata[3:0];
          end
          `ATS_OFS_MODE3: begin
            next_s.prdata = {24'h0, s.mode3};
            if (pwrite) next_s.mode3 = pwdata[7:0];
          end
          `ATS_OFS_MONA: begin
            next_s.prdata = {26'h0, s.mona};
            if (pwrite) next_s.mona = pwdata[5:0];
          end
          `ATS_OFS_MONB: begin
            next_s.prdata = {26'h0, s.monb};
            if (pwrite) next_s.monb = pwdata[5:0];
          end
          `ATS_OFS_CMPA: begin
            next_s.prdata = {20'h0, s.cmpa};
            if (pwrite) next_s.cmpa = pwdata[11:0];
          end
          `ATS_OFS_CMPB: begin
            next_s.prdata = {20'h0, s.cmpb};
            if (pwrite) next_s.cmpb = pwdata[11:0];
          end
          `ATS_OFS_STATUS: begin
            next_s.prdata = {17'h0, s.slot, s.prog, s.kind, s.st[1], s.tpend, s.mpend == 6'h0};
          end
          `ATS_OFS_PSEL: begin
            next_s.prdata = {14'h0, s.psel};
            if (pwrite) next_s.psel = pwdata[17:0];
          end
          `ATS_OFS_PINTS: begin
            next_s.prdata = {20'h0, s.pints};
            if (pwrite) next_s.pints = pwdata[11:0];
          end
          default: next_s.pslverr = 1'b1; // Unmapped
        endcase
      end
    end
    // Highest pending trigger
    if (next_s.mpend != 6'h0) want = ats_pkg::K_MOTOR;
    else if (next_s.tpend) want = ats_pkg::K_TIMER;
    else if (next_s.spend) want = ats_pkg::K_SOFT;
    else if (next_s.cen) want = ats_pkg::K_CONST;
    for (int i = 5; i >= 0; i--) begin
      if (next_s.mpend[i]) j = 3'(i);
    end
    // Sequencer
    case (s.st)
      ats_pkg::ST_BUSY: begin
        if (!s.en) begin
          // Disable drops the conversion, nothing stored
          next_s.cabort = 1'b1;
          next_s.st = ats_pkg::ST_IDLE;
          next_s.kind = ats_pkg::K_NONE;
        end else if (rank(want) > rank(s.kind)) begin
          // Preempted; pending soft/timer stays set, so it reruns from slot 0
          next_s.cabort = 1'b1;
          next_s.st = ats_pkg::ST_IDLE;
          next_s.kind = ats_pkg::K_NONE;
        end else if (conv_done) begin
          next_s.res[s.slot] = conv_data;
          next_s.ovr[s.slot] = next_s.ovr[s.slot] | s.rf[s.slot];
          next_s.rf[s.slot] = 1'b1;
          // Compare as the result is fixed
          if (s.mona[`ATS_MON_EN] && s.mona[3:0] == s.slot &&
              ((conv_data >= s.cmpa) == s.mona[`ATS_MON_BIG])) begin
            next_s.mon[0] = 1'b1;
          end
          if (s.monb[`ATS_MON_EN] && s.monb[3:0] == s.slot &&
              ((conv_data >= s.cmpb) == s.monb[`ATS_MON_BIG])) begin
            next_s.mon[1] = 1'b1;
          end
          next_s = issue(next_s, s.slot + 4'h1);
        end
      end
      ats_pkg::ST_IDLE: begin
        if (s.en && want != ats_pkg::K_NONE) begin
          next_s.kind = want;
          next_s.prog = 3'h0;
          if (want == ats_pkg::K_MOTOR) begin
            next_s.prog = s.psel[j*3 +: 3];
            // A repeat pulse on the launching edge stays queued
            next_s.mpend[j] = s.mpend[j] & motor_trigger_in[j];
          end
          next_s = issue(next_s, 4'h0);
        end
      end
      default: next_s.st = ats_pkg::ST_IDLE;
    endcase
    // A request landing on the finishing edge must not be lost
    next_s.tpend = next_s.tpend | timer_start_pulse;
    if (psel && penable && !s.pready && pwrite && a == `ATS_OFS_CTRL) begin
      next_s.spend = next_s.spend | pwdata[`ATS_CTRL_SOFT];
    end
    // Motor and timer triggers are not held while the converter is off; a soft request stays pending
    if (!next_s.en) begin
      next_s.mpend = 6'h0;
      next_s.tpend = 1'b0;
      // No start once disabled; a busy state aborts next cycle
      next_s.cstart = 1'b0;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= ats_pkg::ST_IDLE;
      s.kind <= ats_pkg::K_NONE;
      s.clk <= `ATS_CLK_RST;
      s.mode3 <= `ATS_MODE3_RST;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign pready = s.pready;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign conv_start = s.cstart;
  assign conv_abort = s.cabort;
  assign conv_input = s.cin;
  assign conv_phase = s.cph;
  assign conv_clock_select_reg = s.clk;
  assign operating_mode_field = s.mode3[2:0];
  assign converter_enable = s.en;
  assign motor_prog_done_irq = s.mdone;
  assign timer_prog_done_irq = s.tdone;
  assign soft_prog_done_irq = s.sdone;
  assign const_prog_done_irq = s.adone;
  assign monitor_match_irq = s.mon;
endmodule
`default_nettype wire

// ===== bench/ats_top_sva.sv
// Port assertions for the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
`include "ats_consts.svh"
module ats_top_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        conv_done,
  input wire logic        conv_start,
  input wire logic        conv_abort,
  input wire logic [3:0]  conv_clock_select_reg,
  input wire logic        converter_enable,
  input wire logic        timer_prog_done_irq,
  input wire logic [1:0]  monitor_match_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase still waiting for its answer
  sequence s_access;
    psel && penable && !pready;
  endsequence
  // Completed write to a given offset
  sequence s_write(logic [7:0] ofs);
    psel && penable && pready && pwrite && paddr == ofs;
  endsequence
  chk_apb_answer_next: assert property (s_access |=> pready)
    else $error("access phase not answered on next edge");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready wider than one cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside an answer");
  chk_unmapped_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  chk_enable_follows_write: assert property (
    s_write(`ATS_OFS_CTRL) |=> converter_enable == $past(pwdata[0]))
    else $error("enable does not follow control write");
  chk_clock_follows_write: assert property (
    s_write(`ATS_OFS_CLK) |=> conv_clock_select_reg == $past(pwdata[3:0]))
    else $error("clock select does not follow write");
  chk_start_needs_enable: assert property (conv_start |-> converter_enable)
    else $error("conversion started while disabled");
  chk_start_abort_apart: assert property (!(conv_start && conv_abort))
    else $error("start and abort together");
  chk_monitor_after_store: assert property (
    monitor_match_irq != 2'b00 |-> $past(conv_done) || $past(conv_done, 2))
    else $error("monitor interrupt without a stored result");
  chk_timer_irq_pulse: assert property (timer_prog_done_irq |=> !timer_prog_done_irq)
    else $error("timer completion wider than one cycle");
endmodule
`default_nettype wire

// ===== bench/ats_conv_model.sv
// Behavioural converter core answering each start that is not aborted after a fixed delay
`timescale 1ns/10ps
`default_nettype none
module ats_conv_model #(
  parameter int DELAY = 6
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        conv_start,
  input  wire logic        conv_abort,
  input  wire logic [2:0]  conv_input,
  output logic             conv_done,
  output logic [11:0]      conv_data
);
  int         left; // Cycles to the answer, 0 when idle
  logic [2:0] chan; // Input latched at start
  // One conversion outstanding; data toggles so no stale value lingers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 0;
      chan <= 3'h0;
      conv_done <= 1'b0;
      conv_data <= 12'h000;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_abort) begin
        left <= 0;
      end else if (conv_start) begin
        left <= DELAY;
        chan <= conv_input;
      end else if (left == 1) begin
        left <= 0;
        conv_done <= 1'b1;
        conv_data <= 12'h5A0 | {9'h000, chan};
      end else if (left > 1) begin
        left <= left - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb_adc_trigger_sequencer.sv
// Register-level tests of the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
`include "ats_consts.svh"
module tb_adc_trigger_sequencer;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [5:0]  motor_trigger_in = 6'h00;
  logic        timer_start_pulse = 1'b0;
  logic        pready, pslverr, conv_done, conv_start, conv_abort, converter_enable;
  logic        timer_prog_done_irq, soft_prog_done_irq, const_prog_done_irq;
  logic [31:0] prdata, rd;
  logic [11:0] conv_data;
  logic [2:0]  conv_input, operating_mode_field;
  logic [1:0]  conv_phase, motor_prog_done_irq, monitor_match_irq;
  logic [3:0]  conv_clock_select_reg;
  logic        err, abort_seen = 1'b0;
  logic [1:0]  mon_seen = 2'h0;   // Monitor pulses seen, bit 1 for B
  logic [1:0]  phase_seen = 2'h0; // Phase carried by the last start
  int          fails = 0, samples_checked = 0, cycles = 0;
  wire logic [4:0] done_irqs; // Completion pulses, motor in the low bits
  assign done_irqs = {const_prog_done_irq, soft_prog_done_irq, timer_prog_done_irq,
                      motor_prog_done_irq};
  ats_top ats_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .motor_trigger_in, .timer_start_pulse, .conv_done,
    .conv_data, .conv_start, .conv_abort, .conv_input, .conv_phase,
    .conv_clock_select_reg, .operating_mode_field, .converter_enable,
    .motor_prog_done_irq, .timer_prog_done_irq, .soft_prog_done_irq,
    .const_prog_done_irq, .monitor_match_irq);
  ats_conv_model ats_conv_model_inst (.pclk, .presetn, .conv_start, .conv_abort,
    .conv_input, .conv_done, .conv_data);
  // Clock, and a ceiling well above the few hundred cycles needed
  initial begin
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    mon_seen <= mon_seen | monitor_match_irq;
    if (conv_start) phase_seen <= conv_phase;
    abort_seen <= abort_seen | conv_abort;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, {31'h0, pready});
  endtask
  task automatic rdchk(input string name, input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    chk(name, exp, rd);
  endtask
  // One-cycle trigger pulse: {timer, motor[5:0]}
  task automatic pulse(input logic [6:0] v);
    @(posedge pclk);
    {timer_start_pulse, motor_trigger_in} <= v;
    @(posedge pclk);
    {timer_start_pulse, motor_trigger_in} <= 7'h00;
  endtask
  task automatic wait_irq(input int i);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (done_irqs[i] !== 1'b1 && n < 500);
    chk("done irq", 32'h1, {31'h0, done_irqs[i]});
  endtask
  task automatic complete_run;
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk("mode field", 32'h4, {29'h0, operating_mode_field});
    rdchk("mode3", `ATS_OFS_MODE3, 32'h4);
    apb(1'b1, `ATS_OFS_MODE3, 32'h4);
    apb(1'b1, `ATS_OFS_CLK, 32'h5);
    chk("clock port", 32'h5, {28'h0, conv_clock_select_reg});
    rdchk("unmapped", 8'h30, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    // Timer program twice without reading: overrun
    apb(1'b1, `ATS_OFS_TSET0, 32'h0083_0081);
    apb(1'b1, `ATS_OFS_CTRL, 32'h1);
    pulse(7'h40);
    wait_irq(2);
    pulse(7'h40);
    wait_irq(2);
    rdchk("res0", `ATS_OFS_RES0, 32'hC000_05A1);
    rdchk("res0 again", `ATS_OFS_RES0, 32'h0000_05A1);
    rdchk("res1", `ATS_OFS_RES0 + 8'h04, 32'h0);
    rdchk("res2", `ATS_OFS_RES0 + 8'h08, 32'hC000_05A3);
    // Timer preempts the software program, which restarts
    apb(1'b1, `ATS_OFS_SSET0, 32'h0000_8400);
    apb(1'b1, `ATS_OFS_CTRL, 32'h3);
    repeat (2) @(posedge pclk);
    pulse(7'h40);
    wait_irq(3);
    chk("abort", 32'h1, {31'h0, abort_seen});
    rdchk("res1 soft", `ATS_OFS_RES0 + 8'h04, 32'h8000_05A4);
    // Motor trigger 0 runs program 2 slot 3, monitors A and B on result 3
    apb(1'b1, `ATS_OFS_PSEL, 32'h2);
    apb(1'b1, `ATS_OFS_PINTS, 32'h30);
    // Slot 3 of set 2: phase 2, out-of-range input code falls to input 0
    apb(1'b1, `ATS_OFS_PSET0 + 8'h08, 32'hD200_0000);
    apb(1'b1, `ATS_OFS_MONA, 32'h33);
    apb(1'b1, `ATS_OFS_CMPA, 32'h0);
    apb(1'b1, `ATS_OFS_MONB, 32'h23);
    apb(1'b1, `ATS_OFS_CMPB, 32'hFFF);
    pulse(7'h01);
    wait_irq(1);
    chk("phase", 32'h2, {30'h0, phase_seen});
    rdchk("res3", `ATS_OFS_RES0 + 8'h0C, 32'h8000_05A0);
    chk("monitors", 32'h3, {30'h0, mon_seen});
    // Constant program loops, then is stopped
    apb(1'b1, `ATS_OFS_ASET0, 32'h80);
    apb(1'b1, `ATS_OFS_CTRL, 32'h5);
    wait_irq(4);
    apb(1'b1, `ATS_OFS_CTRL, 32'h1);
    apb(1'b0, `ATS_OFS_RES0, 32'h0);
    chk("res0 const", 32'h8000_05A0, rd & 32'h8000_0FFF);
    // Disable mid-conversion: nothing stored
    apb(1'b1, `ATS_OFS_CTRL, 32'h3);
    apb(1'b1, `ATS_OFS_CTRL, 32'h0);
    rdchk("res1 kept", `ATS_OFS_RES0 + 8'h04, 32'h0000_05A4);
    complete_run();
  end
endmodule
bind ats_top ats_top_sva ats_top_sva_inst (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .prdata, .pslverr, .conv_done, .conv_start, .conv_abort,
  .conv_clock_select_reg, .converter_enable, .timer_prog_done_irq, .monitor_match_irq);
`default_nettype wire
